// *** hdl/crib_bank.sv ***
// Functional notes
// R1: Separate left/right gain, 1 dB steps, +-15.
// R2: Gain field is signed two's-complement decibels.
// R3: Gain changes follow smoothing selection, not instant; code applies the target at once when SM_INSTANT is selected.
// R4: Phase-align bit forces both serial ports in phase.
// R5: De-emphasis field applies only under forced lock.
// R6: Pin style: high, low, open-drain low.
// R7: Error sample policy: hold, zero, pass.
// R8: Pass-through output follows selected receiver input.
// R9: Receiver input chosen by separate 3-bit code.
// R10: Status bit sticky until status read.
// R11: Status read clears every status bit.
// R12: Masked status bit always reads zero.
// R13: Bit 7 flags clock-recovery lock loss.
// R14: Bits 5,4,3 flag subcode, cstat, ustat updates.
// R15: Bit 1 flags ADC over-range.
// R16: Bit 0 flags any enabled receiver error.
// R17: Mask gates pin and status; resets zero.
// R18: Mask bits align with status bits.
// R19: Trigger code from high/low mode registers.
// R20: Rising, falling or level activation.
// R21: Pin polarity set by style field only.
// R22: Enabled errors feed bit 0; CRC spares samples.
// R23: Edge modes latch pin; level follows condition.
// R24: Host writes no reserved codes or bits.
`include "crib_params.svh"

module crib_bank
	import crib_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              ce_i,
	input  wire logic [7:0]        addr_i,
	input  wire logic              wr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	output logic                   rvalid_o,
	input  wire logic [1:0]        change_smoothing_select_i,
	input  wire logic              zero_cross_i,
	input  wire logic              ramp_tick_i,
	output logic signed [5:0]      left_gain_code_o,
	output logic signed [5:0]      right_gain_code_o,
	output logic                   port_phase_align_o,
	input  wire logic              forced_lock_enable_i,
	output logic      [1:0]        deemph_select_o,
	input  wire logic [7:0]        receiver_input_pins_i,
	output logic                   passthrough_out_o,
	output logic                   receiver_in_o,
	input  wire logic              pll_unlock_i,
	input  wire logic              qsub_new_i,
	input  wire logic              cstat_update_i,
	input  wire logic              ustat_update_i,
	input  wire logic              adc_overrange_i,
	input  wire logic [6:0]        rx_err_bits_i,
	input  wire logic [6:0]        rx_err_enable_i,
	input  wire logic [23:0]       rx_sample_i,
	input  wire logic              rx_sample_valid_i,
	output logic      [23:0]       sample_o,
	output logic                   int_o,
	output logic                   int_oe_o
);

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------

	// Limit a code to the usable range; codes past it saturate.
	function automatic logic signed [5:0] clamp_gain(input logic signed [5:0] g);
		if (g > `CRIB_GAIN_MAX)
			return `CRIB_GAIN_MAX;
		else if (g < `CRIB_GAIN_MIN)
			return `CRIB_GAIN_MIN;
		else
			return g;
	endfunction

	// Move the applied gain one decibel toward the target.
	function automatic logic signed [5:0] step_gain(input logic signed [5:0] cur,
		input logic signed [5:0] tgt);
		if (cur < tgt)
			return cur + 6'sd1;
		else if (cur > tgt)
			return cur - 6'sd1;
		else
			return cur;
	endfunction

	// ----------------------------------------
	// Registers.
	// ----------------------------------------
	logic [7:0]        gain_l_ff;     // Left gain register.
	logic [7:0]        gain_r_ff;     // Right gain register.
	logic [7:0]        mode_ff;       // Receiver mode register.
	logic [7:0]        route_ff;      // Input routing register.
	logic [7:0]        stat_ff;       // Sticky interrupt flags.
	logic [7:0]        mask_ff;       // Interrupt enable mask.
	logic [7:0]        trig_hi_ff;    // Trigger code high bits.
	logic [7:0]        trig_lo_ff;    // Trigger code low bits.
	logic [7:0]        cond_prev_ff;  // Conditions one cycle ago.
	logic [7:0]        rxp_meta_ff;   // First synchroniser stage.
	logic [7:0]        rxp_sync_ff;   // Second synchroniser stage.
	logic signed [5:0] app_l_ff;      // Applied left gain.
	logic signed [5:0] app_r_ff;      // Applied right gain.
	logic [23:0]       last_good_ff;  // Last sample without an audio-affecting error.

	// ----------------------------------------
	// Decode.
	// ----------------------------------------
	wire sel_stat = (addr_i == `CRIB_ADDR_STATUS);
	wire rd_stat  = ce_i && rd_i && sel_stat;
	wire wr_en    = ce_i && wr_i;

	// Enabled receiver errors raise bit 0; only non-CRC ones touch audio.
	wire [6:0] err_on     = rx_err_bits_i & rx_err_enable_i;  // R22
	wire       rx_err     = |err_on;                          // R16
	wire       audio_err  = |(err_on & `CRIB_AUDIO_ERR_MASK); // R22

	// Condition vector laid out in status bit order, gaps held low.
	wire [7:0] cond;
	assign cond = {pll_unlock_i, 1'b0, qsub_new_i, cstat_update_i,  // R13 R14
		ustat_update_i, 1'b0, adc_overrange_i, rx_err};             // R14 R15 R16

	// ----------------------------------------
	// Per-source trigger decode.
	// ----------------------------------------
	logic [7:0] event_vec;   // Trigger fired this cycle.
	logic [7:0] level_vec;   // Source is in level mode.

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_src
			crib_trig_e code;
			assign code = crib_trig_e'({trig_hi_ff[gi], trig_lo_ff[gi]});  // R19
			assign level_vec[gi] = (code == TRIG_LEVEL);
			// Rising catches arrival, falling catches removal, level the presence.
			assign event_vec[gi] = (code == TRIG_RISE) ? (cond[gi] & ~cond_prev_ff[gi]) :  // R20
				(code == TRIG_FALL) ? (~cond[gi] & cond_prev_ff[gi]) :
				(code == TRIG_LEVEL) ? cond[gi] : 1'b0;
		end
	endgenerate

	// Mask sits bit for bit over the status flags.
	wire [7:0] set_vec  = event_vec & mask_ff & `CRIB_ST_USED;  // R17 R18
	wire [7:0] nxt_stat = (rd_stat ? 8'h00 : stat_ff) | set_vec; // R10 R11

	// Edge modes hold the pin until read, level mode tracks the source.
	wire int_act = |(stat_ff & ~level_vec) | |(mask_ff & level_vec & cond);  // R23

	// ----------------------------------------
	// Read data.
	// ----------------------------------------
	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (addr_i)
			`CRIB_ADDR_GAIN_L:  rd_mux = gain_l_ff;
			`CRIB_ADDR_GAIN_R:  rd_mux = gain_r_ff;
			`CRIB_ADDR_RX_MODE: rd_mux = mode_ff;
			`CRIB_ADDR_ROUTE:   rd_mux = route_ff;
			`CRIB_ADDR_STATUS:  rd_mux = stat_ff & mask_ff;  // R12
			`CRIB_ADDR_MASK:    rd_mux = mask_ff;
			`CRIB_ADDR_TRIG_HI: rd_mux = trig_hi_ff;
			`CRIB_ADDR_TRIG_LO: rd_mux = trig_lo_ff;
			default:            rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Field views.
	// ----------------------------------------
	wire crib_pin_e    style  = crib_pin_e'(mode_ff[`CRIB_PINSTYLE_LSB +: 2]);
	wire crib_policy_e policy = crib_policy_e'(mode_ff[`CRIB_POLICY_LSB +: 2]);
	wire crib_smooth_e smooth = crib_smooth_e'(change_smoothing_select_i);
	wire [2:0] tx_sel = route_ff[`CRIB_TXSEL_LSB +: 3];
	wire [2:0] rx_sel = route_ff[`CRIB_RXSEL_LSB +: 3];

	// Gain fields are signed decibel codes.
	wire signed [5:0] tgt_l = clamp_gain($signed(gain_l_ff[`CRIB_GAIN_MSB:0]));  // R1 R2
	wire signed [5:0] tgt_r = clamp_gain($signed(gain_r_ff[`CRIB_GAIN_MSB:0]));  // R1 R2

	// Step permission per smoothing choice; both means a ramp tick at zero.
	wire step_ok = (smooth == SM_ZEROX) ? zero_cross_i :   // R3
		(smooth == SM_RAMP) ? ramp_tick_i :
		(smooth == SM_BOTH) ? (ramp_tick_i & zero_cross_i) : 1'b1;

	wire signed [5:0] nxt_app_l = (smooth == SM_INSTANT) ? tgt_l :
		(step_ok ? step_gain(app_l_ff, tgt_l) : app_l_ff);    // R3
	wire signed [5:0] nxt_app_r = (smooth == SM_INSTANT) ? tgt_r :
		(step_ok ? step_gain(app_r_ff, tgt_r) : app_r_ff);    // R3

	// Sample treatment on an audio-affecting error.
	wire [23:0] nxt_sample = !audio_err ? rx_sample_i :
		(policy == POL_HOLD) ? last_good_ff :                   // R7
		(policy == POL_ZERO) ? 24'h00_0000 : rx_sample_i;

	// ----------------------------------------
	// Register writes and status.
	// ----------------------------------------
	// Reserved bit positions are kept at zero so reads never echo them.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			gain_l_ff  <= `CRIB_RST_BYTE;
			gain_r_ff  <= `CRIB_RST_BYTE;
			mode_ff    <= `CRIB_RST_BYTE;
			route_ff   <= `CRIB_RST_BYTE;
			stat_ff    <= `CRIB_RST_BYTE;
			mask_ff    <= `CRIB_RST_BYTE;  // R17
			trig_hi_ff <= `CRIB_RST_BYTE;
			trig_lo_ff <= `CRIB_RST_BYTE;
		end
		else if (ce_i)
		begin
			stat_ff <= nxt_stat;  // R10 R11
			if (wr_i && addr_i == `CRIB_ADDR_GAIN_L)  gain_l_ff  <= wdata_i & 8'h3f;
			if (wr_i && addr_i == `CRIB_ADDR_GAIN_R)  gain_r_ff  <= wdata_i & 8'h3f;
			if (wr_i && addr_i == `CRIB_ADDR_RX_MODE) mode_ff    <= wdata_i & 8'hbf;
			if (wr_i && addr_i == `CRIB_ADDR_ROUTE)   route_ff   <= wdata_i & 8'h77;
			if (wr_i && addr_i == `CRIB_ADDR_MASK)    mask_ff    <= wdata_i & `CRIB_ST_USED;
			if (wr_i && addr_i == `CRIB_ADDR_TRIG_HI) trig_hi_ff <= wdata_i & `CRIB_ST_USED;
			if (wr_i && addr_i == `CRIB_ADDR_TRIG_LO) trig_lo_ff <= wdata_i & `CRIB_ST_USED;
		end
	end

	// Read answer lands one cycle after the strobe.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			rvalid_o <= rd_i;
			if (rd_i)
				rdata_o <= rd_mux;
		end
	end

	// ----------------------------------------
	// Pins, routing and datapath state.
	// ----------------------------------------
	// Receiver inputs are asynchronous pins, so two stages before the muxes.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rxp_meta_ff       <= 8'h00;
			rxp_sync_ff       <= 8'h00;
			cond_prev_ff      <= 8'h00;
			passthrough_out_o <= 1'b0;
			receiver_in_o     <= 1'b0;
			app_l_ff          <= 6'sd0;
			app_r_ff          <= 6'sd0;
			last_good_ff      <= 24'h00_0000;
			sample_o          <= 24'h00_0000;
			int_o             <= 1'b0;
			int_oe_o          <= 1'b1;
			deemph_select_o   <= 2'b00;
		end
		else if (ce_i)
		begin
			rxp_meta_ff       <= receiver_input_pins_i;
			rxp_sync_ff       <= rxp_meta_ff;
			cond_prev_ff      <= cond;
			passthrough_out_o <= rxp_sync_ff[tx_sel];  // R8
			receiver_in_o     <= rxp_sync_ff[rx_sel];  // R9
			app_l_ff          <= nxt_app_l;
			app_r_ff          <= nxt_app_r;
			// De-emphasis choice only means something under forced lock.
			deemph_select_o   <= forced_lock_enable_i ?
				mode_ff[`CRIB_DEEMPH_LSB +: 2] : 2'b00;  // R5
			if (rx_sample_valid_i)
			begin
				sample_o <= nxt_sample;
				if (!audio_err)
					last_good_ff <= rx_sample_i;
			end
			// Polarity depends on style alone, never on trigger mode.
			unique case (style)  // R6 R21
				PIN_HIGH:       begin int_o <= int_act;  int_oe_o <= 1'b1;    end
				PIN_LOW:        begin int_o <= ~int_act; int_oe_o <= 1'b1;    end
				PIN_OPEN_DRAIN: begin int_o <= 1'b0;     int_oe_o <= int_act; end
				PIN_RSVD:       begin int_o <= 1'b0;     int_oe_o <= 1'b0;    end
			endcase
		end
	end

	// Gain and alignment outputs come straight from their flops.
	assign left_gain_code_o   = app_l_ff;   // R1
	assign right_gain_code_o  = app_r_ff;   // R1
	assign port_phase_align_o = mode_ff[`CRIB_ALIGN_BIT];  // R4

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	property p_read_clear;
		rd_stat && set_vec == 8'h00 |=> stat_ff == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared"); // R11

	property p_sticky;
		ce_i && !rd_stat |=> (stat_ff & $past(stat_ff)) == $past(stat_ff);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost"); // R10

	property p_masked_read;
		ce_i && rd_i && sel_stat |=> rdata_o == ($past(stat_ff) & $past(mask_ff)) && rvalid_o;
	endproperty
	a_masked_read: assert property (p_masked_read) else $error("masked bit read"); // R12

	property p_unlock_set;
		ce_i && set_vec[`CRIB_ST_UNLOCK] |=> stat_ff[`CRIB_ST_UNLOCK];
	endproperty
	a_unlock_set: assert property (p_unlock_set) else $error("unlock flag missed"); // R13

	property p_rxerr_set;
		ce_i && mask_ff[0] && level_vec[0] && |(rx_err_bits_i & rx_err_enable_i)
			|=> stat_ff[`CRIB_ST_RXERR];
	endproperty
	a_rxerr_set: assert property (p_rxerr_set) else $error("rx error flag missed"); // R16

	property p_mask_block;
		ce_i && !rd_stat && mask_ff == 8'h00 |=> stat_ff == $past(stat_ff);
	endproperty
	a_mask_block: assert property (p_mask_block) else $error("masked source set"); // R17

	property p_pin_high;
		ce_i && style == PIN_HIGH |=> int_o == $past(int_act) && int_oe_o;
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("pin level wrong"); // R6

	property p_open_drain;
		ce_i && style == PIN_OPEN_DRAIN |=> !int_o && int_oe_o == $past(int_act);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain wrong"); // R21

	property p_passthrough;
		ce_i |=> passthrough_out_o == $past(rxp_sync_ff[tx_sel]);
	endproperty
	a_passthrough: assert property (p_passthrough) else $error("pass-through wrong"); // R8

	property p_zero_sample;
		ce_i && rx_sample_valid_i && audio_err && policy == POL_ZERO |=> sample_o == 24'h00_0000;
	endproperty
	a_zero_sample: assert property (p_zero_sample) else $error("sample not zeroed"); // R7

	property p_deemph;
		ce_i && !forced_lock_enable_i |=> deemph_select_o == 2'b00;
	endproperty
	a_deemph: assert property (p_deemph) else $error("de-emphasis leaked"); // R5

	property p_gain_wait;
		ce_i && smooth != SM_INSTANT && !step_ok |=> $stable(left_gain_code_o);
	endproperty
	a_gain_wait: assert property (p_gain_wait) else $error("gain jumped"); // R3

	property p_gain_instant;
		ce_i && smooth == SM_INSTANT |=> left_gain_code_o == $past(tgt_l);
	endproperty
	a_gain_instant: assert property (p_gain_instant) else $error("gain not applied"); // R3

	c_read_flags: cover property (rd_stat && stat_ff != 8'h00);
	c_open_drain: cover property (style == PIN_OPEN_DRAIN && int_oe_o);
	c_ramp_done:  cover property (smooth == SM_RAMP && app_l_ff != tgt_l ##[1:40] app_l_ff == tgt_l);

endmodule

// *** hdl/crib_params.svh ***
`ifndef CRIB_PARAMS_SVH
`define CRIB_PARAMS_SVH

// ----------------------------------------
// Register offsets on the control port.
// ----------------------------------------
`define CRIB_ADDR_GAIN_L    8'h1c
`define CRIB_ADDR_GAIN_R    8'h1d
`define CRIB_ADDR_RX_MODE   8'h1e
`define CRIB_ADDR_ROUTE     8'h1f
`define CRIB_ADDR_STATUS    8'h20
`define CRIB_ADDR_MASK      8'h21
`define CRIB_ADDR_TRIG_HI   8'h22
`define CRIB_ADDR_TRIG_LO   8'h23

// ----------------------------------------
// Reset values.
// ----------------------------------------
`define CRIB_RST_BYTE       8'h00

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define CRIB_GAIN_MSB       5
`define CRIB_ALIGN_BIT      7
`define CRIB_DEEMPH_LSB     4
`define CRIB_PINSTYLE_LSB   2
`define CRIB_POLICY_LSB     0
`define CRIB_TXSEL_LSB      4
`define CRIB_RXSEL_LSB      0
`define CRIB_ST_UNLOCK      7
`define CRIB_ST_QSUB        5
`define CRIB_ST_CSTAT       4
`define CRIB_ST_USTAT       3
`define CRIB_ST_OVER        1
`define CRIB_ST_RXERR       0
`define CRIB_ST_USED        8'hbb
`define CRIB_AUDIO_ERR_MASK 7'h1f

// ----------------------------------------
// Gain limits in decibels.
// ----------------------------------------
`define CRIB_GAIN_MAX       6'sh0f
`define CRIB_GAIN_MIN       6'sh31

`endif

// *** hdl/crib_pkg.sv ***
// ----------------------------------------
// Shared types of the codec control bank.
// ----------------------------------------
package crib_pkg;

	// Per-source trigger code, high bit from the high mode register.
	typedef enum logic [1:0] {TRIG_RISE, TRIG_FALL, TRIG_LEVEL, TRIG_RSVD} crib_trig_e;

	// Interrupt pin style.
	typedef enum logic [1:0] {PIN_HIGH, PIN_LOW, PIN_OPEN_DRAIN, PIN_RSVD} crib_pin_e;

	// Sample treatment on a receiver error.
	typedef enum logic [1:0] {POL_HOLD, POL_ZERO, POL_PASS, POL_RSVD} crib_policy_e;

	// Gain change smoothing.
	typedef enum logic [1:0] {SM_INSTANT, SM_ZEROX, SM_RAMP, SM_BOTH} crib_smooth_e;

endpackage

// *** bench/crib_host_model.sv ***
// ----------------------------------------
// Host processor on the control port.
// ----------------------------------------
module crib_host_model
(
	input  wire logic       clk_i,
	output logic            ce_o,
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// The bus starts idle with the clock enable running.
	initial
	begin
		ce_o    = 1'b1;
		addr_o  = 8'h00;
		wr_o    = 1'b0;
		wdata_o = 8'h00;
		rd_o    = 1'b0;
	end

	// One byte write; callers pass only defined codes and zero reserved bits.
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		// A released bus shows junk, so stale values cannot pass for fresh ones.
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask

	// One byte read; the answer is registered one cycle after the strobe.
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		// Taken at the next rising edge, where the registered answer still stands.
		@(posedge clk_i);
		v = rvalid_i;
		d = rdata_i;
	endtask
endmodule

// *** bench/test_codec_rx_irq_control_bank.sv ***
// ----------------------------------------
// Self-checking bench of the control bank.
// ----------------------------------------
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module test_codec_rx_irq_control_bank;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clk_i, reset_i, ce, wr, rd, rvalid, sm_tick, zc, fl;
	logic        [7:0]  addr, wdata, rdata, pins, cond;
	logic        [1:0]  sm_sel, deemph;
	logic signed [5:0]  gain_l, gain_r;
	logic               align, pass_o, rxin_o, sval, int_o, int_oe;
	logic        [6:0]  errb, erren;
	logic        [23:0] samp, samp_o;
	int                 mismatches, comparisons, cycles;

	crib_bank i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .addr_i(addr),
		.wr_i(wr), .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .rvalid_o(rvalid),
		.change_smoothing_select_i(sm_sel), .zero_cross_i(zc), .ramp_tick_i(sm_tick),
		.left_gain_code_o(gain_l), .right_gain_code_o(gain_r), .port_phase_align_o(align),
		.forced_lock_enable_i(fl), .deemph_select_o(deemph), .receiver_input_pins_i(pins),
		.passthrough_out_o(pass_o), .receiver_in_o(rxin_o), .pll_unlock_i(cond[7]),
		.qsub_new_i(cond[5]), .cstat_update_i(cond[4]), .ustat_update_i(cond[3]),
		.adc_overrange_i(cond[1]), .rx_err_bits_i(errb), .rx_err_enable_i(erren),
		.rx_sample_i(samp), .rx_sample_valid_i(sval), .sample_o(samp_o),
		.int_o(int_o), .int_oe_o(int_oe));

	crib_host_model i_host (.clk_i(clk_i), .ce_o(ce), .addr_o(addr), .wr_o(wr),
		.wdata_o(wdata), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));

	// ----------------------------------------
	// Clock, hang guard and verdict.
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// The whole run needs about five hundred cycles; the ceiling leaves slack.
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Shared helpers.
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Reads one register and checks both the valid pulse and the byte.
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		i_host.read(a, d, v);
		`CHK(nm, 1'b1, v)
		`CHK(nm, e, d)
	endtask

	// Sends one sample and checks what the output stage made of it.
	task automatic send(input logic [23:0] s, input logic [23:0] e);
		@(posedge clk_i);
		samp <= s;
		sval <= 1'b1;
		@(posedge clk_i);
		sval <= 1'b0;
		cyc(2);
		`CHK("sample", e, samp_o)
	endtask

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	// Every mapped register, and one unmapped place, reads zero after reset.
	task automatic t_reset();
		for (int a = 'h1c; a <= 'h24; a++)
			rd_chk("reset value", 8'(a), 8'h00);
		`CHK("pin idle", 2'b01, {int_o, int_oe})
	endtask

	// Extreme gains apply at once; a ramped change moves one step per tick only.
	task automatic t_gain();
		i_host.write(8'h1c, 8'h31);
		i_host.write(8'h1d, 8'h0f);
		cyc(2);
		`CHK("gain left", 6'h31, gain_l)
		`CHK("gain right", 6'h0f, gain_r)
		rd_chk("gain read", 8'h1c, 8'h31);
		i_host.write(8'h1c, 8'h30);
		cyc(2);
		`CHK("gain clamp", 6'h31, gain_l)
		sm_sel <= 2'b10;
		i_host.write(8'h1d, 8'h0c);
		cyc(3);
		`CHK("gain held", 6'h0f, gain_r)
		sm_tick <= 1'b1;
		@(posedge clk_i);
		sm_tick <= 1'b0;
		cyc(2);
		`CHK("gain step", 6'h0e, gain_r)
		// Zero-cross mode steps on a crossing; the combined mode needs both at once.
		sm_sel <= 2'b01;
		zc     <= 1'b1;
		@(posedge clk_i);
		zc <= 1'b0;
		cyc(2);
		`CHK("gain zero cross", 6'h0d, gain_r)
		sm_sel  <= 2'b11;
		sm_tick <= 1'b1;
		cyc(2);
		`CHK("gain tick alone", 6'h0d, gain_r)
		zc <= 1'b1;
		@(posedge clk_i);
		sm_tick <= 1'b0;
		zc      <= 1'b0;
		cyc(2);
		`CHK("gain both", 6'h0c, gain_r)
	endtask

	// With the enable low a write is dropped and the applied gain stays put.
	task automatic t_freeze();
		i_host.ce_o <= 1'b0;
		i_host.write(8'h1c, 8'h05);
		`CHK("frozen gain", 6'h31, gain_l)
		i_host.ce_o <= 1'b1;
		rd_chk("frozen write", 8'h1c, 8'h30);
	endtask

	// Filter code shows only under forced lock; the align bit drives its output.
	task automatic t_mode();
		for (int c = 1; c < 4; c++)
		begin
			i_host.write(8'h1e, {2'b10, 2'(c), 4'h0});
			fl <= 1'b0;
			cyc(2);
			`CHK("deemph unlocked", 2'b00, deemph)
			fl <= 1'b1;
			cyc(2);
			`CHK("deemph", 2'(c), deemph)
			`CHK("align", 1'b1, align)
		end
		i_host.write(8'h1e, 8'h00);
		cyc(2);
		`CHK("align off", 1'b0, align)
	endtask

	// Each input goes to the pass-through while the receiver takes another one.
	task automatic t_route();
		for (int i = 0; i < 8; i++)
		begin
			i_host.write(8'h1f, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
			pins <= 8'(1 << i);
			cyc(5);
			`CHK("passthrough", 2'b10, {pass_o, rxin_o})
			pins <= 8'(1 << (7 - i));
			cyc(5);
			`CHK("receiver in", 2'b01, {pass_o, rxin_o})
		end
	endtask

	// Each source but bit 0 alone: masked it is silent, enabled it sets its own bit.
	task automatic t_sources();
		int srcs[5] = '{7, 5, 4, 3, 1};
		foreach (srcs[k])
		begin
			i_host.write(8'h21, 8'hbb & ~8'(1 << srcs[k]));
			cond[srcs[k]] <= 1'b1;
			cyc(4);
			`CHK("masked pin", 1'b0, int_o)
			rd_chk("masked flag", 8'h20, 8'h00);
			cond[srcs[k]] <= 1'b0;
			i_host.write(8'h21, 8'(1 << srcs[k]));
			cond[srcs[k]] <= 1'b1;
			cyc(4);
			`CHK("source pin", 1'b1, int_o)
			cond[srcs[k]] <= 1'b0;
			rd_chk("source flag", 8'h20, 8'(1 << srcs[k]));
			rd_chk("flag cleared", 8'h20, 8'h00);
			cyc(3);
			`CHK("pin released", 1'b0, int_o)
		end
	endtask

	// Rising, falling and level codes, judged after arrival and after removal.
	task automatic t_trig();
		logic [1:0] e1[3] = '{2'b11, 2'b01, 2'b10};
		logic [7:0] d;
		logic       v;
		i_host.write(8'h21, 8'h20);
		for (int k = 0; k < 3; k++)
		begin
			i_host.read(8'h20, d, v);
			i_host.write(8'h22, k == 2 ? 8'h20 : 8'h00);
			i_host.write(8'h23, k == 1 ? 8'h20 : 8'h00);
			cond[5] <= 1'b1;
			cyc(4);
			`CHK("trig arrive", e1[k][1], int_o)
			cond[5] <= 1'b0;
			cyc(4);
			`CHK("trig remove", e1[k][0], int_o)
		end
		i_host.write(8'h22, 8'h00);
		i_host.write(8'h23, 8'h00);
	endtask

	// Pin levels per style; open drain idle is judged on its enable only.
	task automatic t_pin();
		logic [1:0] idl[3] = '{2'b01, 2'b11, 2'b00};
		logic [1:0] msk[3] = '{2'b11, 2'b11, 2'b01};
		logic [1:0] act[3] = '{2'b11, 2'b01, 2'b01};
		logic [7:0] d;
		logic       v;
		i_host.write(8'h21, 8'h80);
		for (int s = 0; s < 3; s++)
		begin
			i_host.write(8'h1e, 8'(s << 2));
			i_host.read(8'h20, d, v);
			cyc(3);
			`CHK("pin idle", idl[s] & msk[s], {int_o, int_oe} & msk[s])
			cond[7] <= 1'b1;
			cyc(4);
			`CHK("pin active", act[s], {int_o, int_oe})
			cond[7] <= 1'b0;
		end
		i_host.read(8'h20, d, v);
	endtask

	// Error policies on audio; a checksum error never alters the sample.
	task automatic t_sample();
		logic [23:0] e[3] = '{24'h123456, 24'h000000, 24'habcdef};
		i_host.write(8'h21, 8'h01);
		erren <= 7'h41;
		for (int p = 0; p < 3; p++)
		begin
			i_host.write(8'h1e, 8'(p));
			// The last pass runs the error source in level mode.
			i_host.write(8'h22, p == 2 ? 8'h01 : 8'h00);
			rd_chk("flag clear", 8'h20, 8'h00);
			errb <= 7'h00;
			send(24'h123456, 24'h123456);
			errb <= 7'h01;
			send(24'habcdef, e[p]);
			errb <= 7'h40;
			send(24'h654321, 24'h654321);
			errb <= 7'h00;
			rd_chk("rx error flag", 8'h20, 8'h01);
		end
		erren <= 7'h00;
		errb  <= 7'h01;
		cyc(4);
		rd_chk("disabled error", 8'h20, 8'h00);
		errb <= 7'h00;
	endtask

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		reset_i = 1'b1;
		sm_sel  = 2'b00;
		sm_tick = 1'b0;
		zc      = 1'b0;
		fl      = 1'b0;
		pins    = 8'h00;
		cond    = 8'h00;
		errb    = 7'h00;
		erren   = 7'h00;
		samp    = 24'h00_0000;
		sval    = 1'b0;
		cycles  = 0;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_gain();
		t_freeze();
		t_mode();
		t_route();
		t_sources();
		t_trig();
		t_pin();
		t_sample();
		end_of_test();
	end
endmodule
